// ==== pkg/fbx_consts.svh ====
// Constants for the float-op and breakpoint execution block.
// Assumes inclusion by bare name from the core file and the bench.
`ifndef FBX_CONSTS_SVH
`define FBX_CONSTS_SVH
`define FBX_SIGN_BIT      31
`define FBX_MAX_LIST      16
`define FBX_IMM_MAX       1020
`define FBX_WORD_BYTES    4
`define FBX_FSC_RESET     32'h0000_0000
`define FBX_CMP_CYCLES    1
`endif

// ==== pkg/fbx_pkg.sv ====
// Types for the float-op and breakpoint execution block.
// Assumes fbx_consts.svh is on the include path.
package fbx_pkg;
  typedef enum logic [3:0] {
    FBX_OP_NONE, FBX_OP_WFS, FBX_OP_MUL, FBX_OP_NEG, FBX_OP_NMLA,
    FBX_OP_NMLS, FBX_OP_NMUL, FBX_OP_POP, FBX_OP_PUSH, FBX_OP_SQRT,
    FBX_OP_STM, FBX_OP_STR, FBX_OP_SUB, FBX_OP_DEBUG_BREAK_INSTR
  } fbx_op_t;
  typedef enum logic [1:0] {FBX_IDLE, FBX_MEM, FBX_DEBUG} fbx_state_t;
endpackage : fbx_pkg

// ==== core/fbx_exec.sv ====
// Execution of float ops, extension register memory ops and breakpoint.
// Assumes a decoded op with register values supplied by the core, and
// a memory port that accepts one word per cycle when mem_ready is high.
`timescale 1ns/10ps
`default_nettype none
`include "fbx_consts.svh"

module fbx_exec #(
  parameter int LIST_MAX = `FBX_MAX_LIST
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                op_valid,
  input  wire fbx_pkg::fbx_op_t    op_code,
  input  wire logic                op_cond_pass,
  input  wire logic                op_dest_given,
  input  wire logic [4:0]          op_dest,
  input  wire logic [4:0]          op_src_a,
  input  wire logic [31:0]         val_core,
  input  wire logic [31:0]         val_d,
  input  wire logic [31:0]         val_a,
  input  wire logic [31:0]         val_b,
  input  wire logic [31:0]         fp_mul,
  input  wire logic [31:0]         fp_add,
  input  wire logic [31:0]         fp_sqrt,
  input  wire logic [31:0]         base_addr,
  input  wire logic                mode_decr,
  input  wire logic                imm_given,
  input  wire logic                imm_sub,
  input  wire logic [9:0]          imm_off,
  input  wire logic [4:0]          list_len,
  input  wire logic [7:0]          brk_imm,
  input  wire logic [3:0]          core_flags_in,
  input  wire logic                mem_ready,
  input  wire logic [31:0]         mem_rdata,
  input  wire logic                debug_resume,
  output logic                     busy,
  output logic                     rf_we,
  output logic [4:0]               rf_waddr,
  output logic [31:0]              rf_wdata,
  output logic [31:0]              float_status_ctrl,
  output logic [3:0]               core_flags,
  output logic                     mem_req,
  output logic                     mem_we,
  output logic [31:0]              mem_addr,
  output logic [31:0]              mem_wdata,
  output logic                     wb_we,
  output logic [31:0]              wb_addr,
  output logic                     debug_halt
);
  // ==========================================================
  // Arithmetic results and issue gate, combinational from the multiplier, base address and op ports
  logic [31:0] nm_prod;
  logic [31:0] op_addr;
  logic        go;
  assign nm_prod = {~fp_mul[`FBX_SIGN_BIT], fp_mul[30:0]};
  // Predicate failure suppresses all ops except breakpoint
  assign go = op_valid && !busy &&
    (op_cond_pass || op_code == fbx_pkg::FBX_OP_DEBUG_BREAK_INSTR);
  assign op_addr = !imm_given ? base_addr :
    imm_sub ? base_addr - {22'h0, imm_off}
            : base_addr + {22'h0, imm_off};

  // ==========================================================
  // Sequencer state
  fbx_pkg::fbx_state_t state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [4:0]  reg_idx_reg, reg_idx_next;
  logic [31:0] addr_reg, addr_next;
  logic        load_reg, load_next;
  logic        rf_we_next, mem_req_next, mem_we_next, wb_we_next;
  logic [4:0]  rf_waddr_next;
  logic [31:0] rf_wdata_next, mem_addr_next, mem_wdata_next, wb_addr_next;
  logic [31:0] fsc_next;

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    reg_idx_next   = reg_idx_reg;
    addr_next      = addr_reg;
    load_next      = load_reg;
    rf_we_next     = 1'b0;
    rf_waddr_next  = op_dest;
    rf_wdata_next  = rf_wdata;
    mem_req_next   = 1'b0;
    mem_we_next    = 1'b0;
    mem_addr_next  = mem_addr;
    mem_wdata_next = mem_wdata;
    wb_we_next     = 1'b0;
    wb_addr_next   = wb_addr;
    fsc_next       = float_status_ctrl;
    case (state_reg)
      fbx_pkg::FBX_IDLE: begin
        if (go) begin
          case (op_code)
            fbx_pkg::FBX_OP_WFS:  fsc_next = val_core;
            fbx_pkg::FBX_OP_MUL: begin
              rf_we_next    = 1'b1;
              rf_waddr_next = op_dest_given ? op_dest : op_src_a;
              rf_wdata_next = fp_mul;
            end
            fbx_pkg::FBX_OP_NEG: begin
              rf_we_next    = 1'b1;
              rf_wdata_next = {~val_b[`FBX_SIGN_BIT], val_b[30:0]};
            end
            // Core feeds the adder p+d for accumulate, p-d for subtract
            fbx_pkg::FBX_OP_NMLA: begin
              rf_we_next    = 1'b1;
              rf_wdata_next = {~fp_add[31], fp_add[30:0]};
            end
            fbx_pkg::FBX_OP_NMLS: begin
              rf_we_next    = 1'b1;
              rf_wdata_next = fp_add;
            end
            fbx_pkg::FBX_OP_NMUL: begin
              rf_we_next    = 1'b1;
              rf_waddr_next = op_dest_given ? op_dest : op_src_a;
              rf_wdata_next = nm_prod;
            end
            fbx_pkg::FBX_OP_SQRT: begin
              rf_we_next    = 1'b1;
              rf_wdata_next = fp_sqrt;
            end
            fbx_pkg::FBX_OP_SUB: begin
              rf_we_next    = 1'b1;
              rf_waddr_next = op_dest_given ? op_dest : op_src_a;
              rf_wdata_next = fp_add;
            end
            fbx_pkg::FBX_OP_STR: begin
              mem_req_next   = 1'b1;
              mem_we_next    = 1'b1;
              mem_addr_next  = op_addr;
              mem_wdata_next = val_d;
              state_next     = fbx_pkg::FBX_MEM;
              cnt_next       = 5'd1;
              reg_idx_next   = op_dest;
              addr_next      = op_addr;
              load_next      = 1'b0;
            end
            fbx_pkg::FBX_OP_POP, fbx_pkg::FBX_OP_PUSH,
            fbx_pkg::FBX_OP_STM: begin
              // Lengths outside 1..LIST_MAX are dropped as undefined
              if (list_len != 5'd0 &&
                  {27'h0, list_len} <= 32'(LIST_MAX)) begin
                load_next    = (op_code == fbx_pkg::FBX_OP_POP);
                cnt_next     = list_len;
                reg_idx_next = op_dest;
                state_next   = fbx_pkg::FBX_MEM;
                // Push and decrement_before start below the base
                if (op_code == fbx_pkg::FBX_OP_PUSH || (op_code ==
                    fbx_pkg::FBX_OP_STM && mode_decr)) begin
                  addr_next = base_addr - {25'h0, list_len, 2'b00};
                  wb_addr_next = base_addr - {25'h0, list_len, 2'b00};
                end else begin
                  addr_next = base_addr;
                  wb_addr_next = base_addr + {25'h0, list_len, 2'b00};
                end
                mem_req_next  = 1'b1;
                mem_we_next   = (op_code != fbx_pkg::FBX_OP_POP);
                mem_addr_next = addr_next;
                mem_wdata_next = val_d;
              end
            end
            fbx_pkg::FBX_OP_DEBUG_BREAK_INSTR: state_next = fbx_pkg::FBX_DEBUG;
            default: ;
          endcase
        end
      end
      fbx_pkg::FBX_MEM: begin
        mem_req_next   = 1'b1;
        mem_we_next    = !load_reg;
        mem_addr_next  = addr_reg;
        mem_wdata_next = mem_wdata;
        if (mem_ready) begin
          if (load_reg) begin
            rf_we_next    = 1'b1;
            rf_waddr_next = reg_idx_reg;
            rf_wdata_next = mem_rdata;
          end
          cnt_next     = cnt_reg - 5'd1;
          reg_idx_next = reg_idx_reg + 5'd1;
          addr_next    = addr_reg + 32'(`FBX_WORD_BYTES);
          mem_addr_next = addr_next;
          mem_wdata_next = val_d;
          if (cnt_reg == 5'd1) begin
            mem_req_next = 1'b0;
            mem_we_next  = 1'b0;
            state_next   = fbx_pkg::FBX_IDLE;
            // Write-back pulses on the last beat of every memory op, single store too; STR leaves wb_addr as it was
            wb_we_next   = 1'b1;
          end
        end
      end
      fbx_pkg::FBX_DEBUG: begin
        if (debug_resume) state_next = fbx_pkg::FBX_IDLE;
      end
      default: state_next = fbx_pkg::FBX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= fbx_pkg::FBX_IDLE;
      cnt_reg           <= 5'h0;
      reg_idx_reg       <= 5'h0;
      addr_reg          <= 32'h0;
      load_reg          <= 1'b0;
      rf_we             <= 1'b0;
      rf_waddr          <= 5'h0;
      rf_wdata          <= 32'h0;
      mem_req           <= 1'b0;
      mem_we            <= 1'b0;
      mem_addr          <= 32'h0;
      mem_wdata         <= 32'h0;
      wb_we             <= 1'b0;
      wb_addr           <= 32'h0;
      float_status_ctrl <= `FBX_FSC_RESET;
      core_flags        <= 4'h0;
      busy              <= 1'b0;
      debug_halt        <= 1'b0;
    end else begin
      state_reg         <= state_next;
      cnt_reg           <= cnt_next;
      reg_idx_reg       <= reg_idx_next;
      addr_reg          <= addr_next;
      load_reg          <= load_next;
      rf_we             <= rf_we_next;
      rf_waddr          <= rf_waddr_next;
      rf_wdata          <= rf_wdata_next;
      mem_req           <= mem_req_next;
      mem_we            <= mem_we_next;
      mem_addr          <= mem_addr_next;
      mem_wdata         <= mem_wdata_next;
      wb_we             <= wb_we_next;
      wb_addr           <= wb_addr_next;
      float_status_ctrl <= fsc_next;
      // Core flags pass through; no op here alters them
      core_flags        <= core_flags_in;
      busy              <= state_next != fbx_pkg::FBX_IDLE;
      debug_halt        <= state_next == fbx_pkg::FBX_DEBUG;
    end
  end

  // ==========================================================
  // Assertions
  a_fsc_copy: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_code == fbx_pkg::FBX_OP_WFS |=> float_status_ctrl ==
    $past(val_core)) else $error("status write lost");
  a_fsc_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(go && op_code == fbx_pkg::FBX_OP_WFS) |=> $stable(float_status_ctrl))
    else $error("status changed by other op");
  a_neg_sign: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_code == fbx_pkg::FBX_OP_NEG |=> rf_we &&
    rf_wdata == ($past(val_b) ^ 32'h8000_0000)) else $error("negate bad");
  a_nmul_neg: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_code == fbx_pkg::FBX_OP_NMUL |=> rf_wdata ==
    ($past(fp_mul) ^ 32'h8000_0000)) else $error("nmul sign bad");
  a_mul_dest: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_code == fbx_pkg::FBX_OP_MUL && !op_dest_given |=>
    rf_waddr == $past(op_src_a)) else $error("mul dest bad");
  a_str_base: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_code == fbx_pkg::FBX_OP_STR && !imm_given |=>
    mem_req && mem_addr == $past(base_addr)) else $error("store addr bad");
  a_debug_break_instr_debug: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && !busy && op_code == fbx_pkg::FBX_OP_DEBUG_BREAK_INSTR |=> debug_halt)
    else $error("breakpoint missed");
  a_db_below: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_code == fbx_pkg::FBX_OP_STM && mode_decr && list_len != 5'd0 &&
    list_len <= 5'd16 |=> mem_addr == $past(base_addr) -
    {25'h0, $past(list_len), 2'b00}) else $error("db addr bad");
  a_flags_keep: assert property (@(posedge clk) disable iff (!rst_n)
    debug_halt && $stable(core_flags_in) |=> $stable(core_flags))
    else $error("flags moved");
  c_pop: cover property (@(posedge clk) go && op_code == fbx_pkg::FBX_OP_POP);
  c_stm: cover property (@(posedge clk) wb_we);
  c_debug_break_instr: cover property (@(posedge clk) debug_halt ##1 !debug_halt);
endmodule : fbx_exec
`default_nettype wire

// ==== dv/fbx_mem_model.sv ====
// Partner model of the load/store memory path, one word per beat.
// Assumes the block holds request, address and data until mem_ready.
`timescale 1ns/10ps
`default_nettype none
module fbx_mem_model (
  input  wire logic        clk,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata
);
  // ==========================================================
  // Beat acceptance and write log
  logic [31:0] log_addr [0:31];
  logic [31:0] log_data [0:31];
  logic [31:0] junk     = 32'h0F0F_0F0F;
  logic [1:0]  wait_cnt = 2'h0;
  int          n_wr     = 0;
  // Slow answers: lat idle cycles before each beat, lat at most 3
  assign mem_ready = mem_req && (wait_cnt >= lat);
  // Outside a beat the read bus toggles, so stale data never matches
  assign mem_rdata = mem_ready ? (mem_addr ^ 32'hA5A5_0000) : junk;
  always @(posedge clk) begin
    junk <= ~junk;
    if (mem_ready) begin
      wait_cnt <= 2'h0;
      if (mem_we) begin
        log_addr[n_wr % 32] <= mem_addr;
        log_data[n_wr % 32] <= mem_wdata;
        n_wr <= n_wr + 1;
      end
    end else if (mem_req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : fbx_mem_model
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for fbx_exec: one task per scenario.
// Assumes fbx_pkg, fbx_consts.svh and fbx_mem_model compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "fbx_consts.svh"
module tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_cond_pass = 1'b1;
  logic op_dest_given = 1'b1, mode_decr = 1'b0, imm_given = 1'b0;
  logic imm_sub = 1'b0, debug_resume = 1'b0, mem_ready, mem_req, mem_we;
  logic busy, rf_we, wb_we, debug_halt;
  logic [4:0]  op_dest = 5'h03, op_src_a = 5'h07, list_len = 5'h01, rf_waddr;
  logic [31:0] val_core = 32'h0, val_d = 32'h0, val_a = 32'h0, val_b = 32'h0;
  logic [31:0] fp_mul = 32'h0, fp_add = 32'h0, fp_sqrt = 32'h0;
  logic [31:0] base_addr = 32'h0, mem_rdata, rf_wdata, float_status_ctrl;
  logic [31:0] mem_addr, mem_wdata, wb_addr, wbv;
  logic [31:0] rw_data [0:3];
  logic [4:0]  rw_addr [0:3];
  logic [9:0]  imm_off = 10'h000;
  logic [7:0]  brk_imm = 8'h00;
  logic [3:0]  core_flags_in = 4'hA, core_flags;
  logic [1:0]  lat = 2'h0;
  fbx_pkg::fbx_op_t op_code = fbx_pkg::FBX_OP_NONE;
  int err_count = 0, n_checks = 0, cyc = 0, rwn, wbn, s;

  fbx_exec i_fbx_exec (.clk, .rst_n, .op_valid, .op_code, .op_cond_pass,
    .op_dest_given, .op_dest, .op_src_a, .val_core, .val_d, .val_a, .val_b,
    .fp_mul, .fp_add, .fp_sqrt, .base_addr, .mode_decr, .imm_given, .imm_sub,
    .imm_off, .list_len, .brk_imm, .core_flags_in, .mem_ready, .mem_rdata,
    .debug_resume, .busy, .rf_we, .rf_waddr, .rf_wdata, .float_status_ctrl,
    .core_flags, .mem_req, .mem_we, .mem_addr, .mem_wdata, .wb_we, .wb_addr,
    .debug_halt);
  fbx_mem_model i_fbx_mem_model (.clk, .lat, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ready, .mem_rdata);

  initial forever #2.5 clk = ~clk;
  // Whole run is under 150 cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic issue(input fbx_pkg::fbx_op_t op);
    @(posedge clk);
    op_code  <= op;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : issue
  // Collects register writes and write-back until busy drops
  task automatic run(input fbx_pkg::fbx_op_t op);
    rwn = 0;
    wbn = 0;
    s = i_fbx_mem_model.n_wr;
    issue(op);
    // Sample first: the last pulse arrives with busy already low
    for (int i = 0; i < 120; i++) begin
      if (rf_we === 1'b1 && rwn < 4) begin
        rw_addr[rwn] = rf_waddr;
        rw_data[rwn] = rf_wdata;
        rwn++;
      end
      if (wb_we === 1'b1) begin
        wbv = wb_addr;
        wbn++;
      end
      if (busy !== 1'b1) i = 120;
      else tick(1);
    end
    chk(busy === 1'b0 && mem_req === 1'b0, "memory op did not end");
    chk(core_flags === core_flags_in, "core flags moved");
  endtask : run
  function automatic logic [31:0] la(input int k);
    return i_fbx_mem_model.log_addr[(s + k) % 32];
  endfunction : la

  // ==========================================================
  // Scenarios
  task automatic t_alu();
    val_core <= 32'hF800_009F;
    issue(fbx_pkg::FBX_OP_WFS);
    tick(3);
    chk(float_status_ctrl === 32'hF800_009F, "status write");
    val_a <= 32'h3FC0_0001;
    val_b <= 32'h3FC0_0001;
    fp_mul <= 32'h4040_0000;
    fp_add <= 32'h4040_0000;
    fp_sqrt <= 32'h3F80_0000;
    // Destination value zero makes both readings of the adder agree
    run(fbx_pkg::FBX_OP_MUL);
    run(fbx_pkg::FBX_OP_NEG);
    run(fbx_pkg::FBX_OP_NMLA);
    run(fbx_pkg::FBX_OP_NMLS);
    run(fbx_pkg::FBX_OP_NMUL);
    run(fbx_pkg::FBX_OP_SQRT);
    fp_add <= 32'hBF00_0000;
    run(fbx_pkg::FBX_OP_SUB);
    $display("test alu done");
  endtask : t_alu
  task automatic t_alu_res();
    logic [31:0] exp [0:6];
    logic [31:0] fa [0:6];
    fbx_pkg::fbx_op_t ops [0:6];
    // Destination 1.0, product 3.0: adder gives 4.0 or 2.0 per variant
    exp = '{32'h4040_0000, 32'hBFC0_0001, 32'hC080_0000, 32'h4000_0000,
            32'hC040_0000, 32'h3F80_0000, 32'hBF00_0000};
    fa = '{32'h0000_0000, 32'h0000_0000, 32'h4080_0000, 32'h4000_0000,
           32'h0000_0000, 32'h0000_0000, 32'hBF00_0000};
    ops = '{fbx_pkg::FBX_OP_MUL, fbx_pkg::FBX_OP_NEG, fbx_pkg::FBX_OP_NMLA,
            fbx_pkg::FBX_OP_NMLS, fbx_pkg::FBX_OP_NMUL, fbx_pkg::FBX_OP_SQRT,
            fbx_pkg::FBX_OP_SUB};
    val_d <= 32'h3F80_0000;
    for (int k = 0; k < 7; k++) begin
      fp_add <= fa[k];
      run(ops[k]);
      chk(rwn == 1 && rw_addr[0] === 5'h03 && rw_data[0] === exp[k],
          "alu result");
    end
    op_dest_given <= 1'b0;
    run(fbx_pkg::FBX_OP_MUL);
    chk(rwn == 1 && rw_addr[0] === 5'h07, "default destination");
    op_cond_pass <= 1'b0;
    run(fbx_pkg::FBX_OP_MUL);
    chk(rwn == 0, "failed predicate still wrote");
    op_cond_pass <= 1'b1;
    $display("test alu results done");
  endtask : t_alu_res
  task automatic t_store();
    val_d <= 32'h1234_5678;
    base_addr <= 32'h0000_0100;
    list_len <= 5'h02;
    run(fbx_pkg::FBX_OP_STM);
    chk(i_fbx_mem_model.n_wr - s == 2 && la(0) === 32'h100 && la(1) === 32'h104
        && i_fbx_mem_model.log_data[s % 32] === 32'h1234_5678, "ia");
    chk(wbn == 1 && wbv === 32'h0000_0108, "ia write-back");
    lat <= 2'h2;
    mode_decr <= 1'b1;
    base_addr <= 32'h0000_0200;
    list_len <= 5'h03;
    run(fbx_pkg::FBX_OP_STM);
    chk(i_fbx_mem_model.n_wr - s == 3 && la(0) === 32'h1F4
        && la(2) === 32'h1FC && wbv === 32'h1F4, "db");
    lat <= 2'h1;
    base_addr <= 32'h0000_0400;
    list_len <= 5'h10;
    run(fbx_pkg::FBX_OP_PUSH);
    chk(i_fbx_mem_model.n_wr - s == 16 && la(0) === 32'h3C0
        && la(15) === 32'h3FC, "push");
    list_len <= 5'h11;
    run(fbx_pkg::FBX_OP_PUSH);
    chk(i_fbx_mem_model.n_wr == s, "oversized list accepted");
    $display("test store multiple done");
  endtask : t_store
  task automatic t_single(input logic g, input logic sb, input logic [9:0] off,
                          input logic [31:0] ea);
    imm_given <= g;
    imm_sub <= sb;
    imm_off <= off;
    base_addr <= 32'h0000_1000;
    run(fbx_pkg::FBX_OP_STR);
    chk(i_fbx_mem_model.n_wr - s == 1 && la(0) === ea, "single store");
    $display("test single store done");
  endtask : t_single
  task automatic t_pop();
    base_addr <= 32'h0000_0300;
    op_dest <= 5'h04;
    list_len <= 5'h02;
    run(fbx_pkg::FBX_OP_POP);
    chk(rwn == 2 && rw_addr[0] === 5'h04 && rw_data[0] === 32'hA5A5_0300
        && rw_addr[1] === 5'h05 && rw_data[1] === 32'hA5A5_0304, "pop");
    list_len <= 5'h00;
    run(fbx_pkg::FBX_OP_POP);
    chk(rwn == 0, "empty list accepted");
    $display("test pop done");
  endtask : t_pop
  task automatic t_debug_break_instr(input logic pass, input logic [7:0] imm);
    op_cond_pass <= pass;
    brk_imm <= imm;
    core_flags_in <= 4'h5;
    issue(fbx_pkg::FBX_OP_DEBUG_BREAK_INSTR);
    tick(2);
    chk(debug_halt === 1'b1, "no debug halt");
    chk(core_flags === 4'h5, "flags moved");
    @(posedge clk);
    debug_resume <= 1'b1;
    @(posedge clk);
    debug_resume <= 1'b0;
    tick(2);
    chk(debug_halt === 1'b0, "halt not released");
    $display("test breakpoint done");
  endtask : t_debug_break_instr

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk(float_status_ctrl === `FBX_FSC_RESET && busy === 1'b0, "reset");
    t_alu();
    t_alu_res();
    t_store();
    mode_decr <= 1'b0;
    lat <= 2'h0;
    t_single(1'b1, 1'b0, 10'd1020, 32'h0000_13FC);
    t_single(1'b1, 1'b1, 10'd8, 32'h0000_0FF8);
    t_single(1'b0, 1'b0, 10'd12, 32'h0000_1000);
    t_pop();
    t_debug_break_instr(1'b0, 8'hAB);
    t_debug_break_instr(1'b1, 8'h00);
    finish_test();
  end
endmodule : tb
`default_nettype wire
